// File: tec_map.vh
// Purpose: Register map and field constants for the timer/event counter block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef TEC_MAP_VH
`define TEC_MAP_VH

`define TEC_OFF_CTRL0 12'h000
`define TEC_OFF_CTRL1 12'h004
`define TEC_OFF_CTRL2 12'h008
`define TEC_OFF_CTRL3 12'h00c
`define TEC_OFF_CNT0 12'h010
`define TEC_OFF_CNT1 12'h014
`define TEC_OFF_CNT2 12'h018
`define TEC_OFF_CNT3 12'h01c
`define TEC_OFF_IRQ_STAT 12'h020
`define TEC_OFF_IRQ_EN 12'h024
`define TEC_OFF_IRQ_CLR 12'h028

`define TEC_MODE_HI 7
`define TEC_MODE_LO 6
`define TEC_CLK_SRC_BIT 5
`define TEC_RUN_BIT 4
`define TEC_EDGE_BIT 3
`define TEC_PSC_HI 2
`define TEC_PSC_LO 0

`define TEC_MODE_NONE 2'h0
`define TEC_MODE_EVENT 2'h1
`define TEC_MODE_TIMER 2'h2
`define TEC_MODE_PULSE 2'h3

`define TEC_CTRL_RST 8'h08
`define TEC_CTRL8_MASK 8'hdf
`define TEC_CTRL16_MASK 8'hf8
`define TEC_WIDE_DIV 2'h3

`endif

// File: tec_unit.v
// Purpose: One count-up timer/event counter unit with preload and reload
// Assumes: Pin and tick inputs synchronous to pclk
// Notes: Width is 8 or 16
`timescale 1ns/1ps
`include "tec_map.vh"

module tec_unit #(
	parameter WIDTH = 8
) (
	input wire pclk,
	input wire presetn,
	input wire [1:0] mode,
	input wire run,
	input wire edge_sel,
	input wire int_tick,
	input wire pin,
	input wire load,
	input wire [WIDTH-1:0] load_data,
	output reg [WIDTH-1:0] count_reg,
	output wire run_clear,
	output reg ovf_reg
);
	reg pin_d_reg;
	reg active_reg;
	wire rise;
	wire fall;
	wire step;
	wire pulse_start;
	wire pulse_end;
	reg [WIDTH-1:0] preload_reg;

	assign rise = pin & ~pin_d_reg;
	assign fall = ~pin & pin_d_reg;
	// Pulse mode waits for its start edge, ends at the return edge
	assign pulse_start = run && mode == `TEC_MODE_PULSE && !active_reg && (edge_sel ? rise : fall);
	assign pulse_end = run && mode == `TEC_MODE_PULSE && active_reg && (edge_sel ? fall : rise);
	assign run_clear = pulse_end;
	assign step = run && (
		(mode == `TEC_MODE_EVENT && (edge_sel ? fall : rise)) ||
		(mode == `TEC_MODE_TIMER && int_tick) ||
		(mode == `TEC_MODE_PULSE && active_reg && !pulse_end && int_tick));

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_d_reg <= 1'b0;
			active_reg <= 1'b0;
			preload_reg <= {WIDTH{1'b0}};
			count_reg <= {WIDTH{1'b0}};
			ovf_reg <= 1'b0;
		end else begin
			pin_d_reg <= pin;
			ovf_reg <= 1'b0;
			if (!run || mode != `TEC_MODE_PULSE || pulse_end)
				active_reg <= 1'b0;
			else if (pulse_start)
				active_reg <= 1'b1;
			if (load) begin
				preload_reg <= load_data;
				count_reg <= load_data;
			end else if (step) begin
				if (&count_reg) begin
					count_reg <= preload_reg;
					ovf_reg <= 1'b1;
				end else begin
					count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // tec_unit

// File: tec_top.v
// Purpose: Four timer/event counters behind an APB slave with interrupt status
// Assumes: Event pins and sub clock tick synchronous to pclk
// Notes: Unmapped reads return zero, writes ignored, no error response
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "tec_map.vh"

// Summary of operation
// - Units 0, 2, 3 count 8 bits; unit 1 counts 16 bits.
// - Each unit runs as interval timer, event counter or pulse-width meter.
// - Software writes a start value; reads return the present count.
// - Timer and pulse-width modes count an internal clock tick.
// - 8-bit units divide the system clock by 1 to 128 via prescale field.
// - 16-bit unit uses system clock over four or sub clock, by bit 5.
// - Event mode adds one per selected pin transition.
// - Mode field 00 none, 01 event, 10 timer, 11 pulse width.
// - Bit 4 runs the counter when set, stops it when clear.
// - Event mode edge bit: 0 counts rising, 1 counts falling edges.
// - Pulse mode edge bit: 0 starts on falling, 1 on rising edge.
// - Overflow raises the unit interrupt, reloads the preload and continues.
// - Pulse mode waits for the active edge before counting.
// - Pulse mode clears run bit when the pin returns; later edges ignored.
// - Prescaler has no effect when counting external pin edges.
module tec_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [3:0] ext_event_pin,
	input wire sub_clk_tick,
	output wire irq
);
	// Build option: nonzero lets the clock-select bit reach the sub clock
	parameter WIDE_SUB_CLK_OPT = 1;

	reg [7:0] ctrl_reg [0:3];
	reg [6:0] psc_reg;
	reg [1:0] wdiv_reg;
	reg [3:0] irq_stat_reg;
	reg [3:0] irq_en_reg;
	wire [3:0] tick;
	wire [3:0] run_clear;
	wire [3:0] ovf;
	wire [3:0] load;
	wire [7:0] cnt8 [0:3];
	wire [15:0] cnt16;
	wire wr;
	wire rd;
	wire [6:0] psc_next;
	integer i;

	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign psc_next = psc_reg + 7'h01;

	// Tick when every prescaler bit below the selected ratio is set
	function tick_sel;
		input [2:0] code;
		input [6:0] div;
		reg [7:0] ext;
		begin
			ext = {div, 1'b1};
			tick_sel = &(ext | ~((8'h01 << code) - 8'h01)) & 1'b1;
			if (code != 3'h0)
				tick_sel = &(ext[7:1] | ~((7'h01 << code) - 7'h01));
		end
	endfunction

	function [7:0] ctrl_mask;
		input [1:0] idx;
		begin
			ctrl_mask = (idx == 2'h1) ? `TEC_CTRL16_MASK : `TEC_CTRL8_MASK;
		end
	endfunction

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psc_reg <= 7'h00;
			wdiv_reg <= 2'h0;
		end else begin
			psc_reg <= psc_next;
			wdiv_reg <= wdiv_reg + 2'h1;
		end
	end

	// Wide unit clock: system clock over four, or sub clock when chosen
	assign tick[1] = (ctrl_reg[1][`TEC_CLK_SRC_BIT] && WIDE_SUB_CLK_OPT != 0) ?
		sub_clk_tick : (wdiv_reg == `TEC_WIDE_DIV);

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_unit
			assign load[g] = wr && paddr == (`TEC_OFF_CNT0 + 4 * g);
			if (g == 1) begin : g_wide
				tec_unit #(.WIDTH(16)) u_unit (
					.pclk(pclk),
					.presetn(presetn),
					.mode(ctrl_reg[g][`TEC_MODE_HI:`TEC_MODE_LO]),
					.run(ctrl_reg[g][`TEC_RUN_BIT]),
					.edge_sel(ctrl_reg[g][`TEC_EDGE_BIT]),
					.int_tick(tick[g]),
					.pin(ext_event_pin[g]),
					.load(load[g]),
					.load_data(pwdata[15:0]),
					.count_reg(cnt16),
					.run_clear(run_clear[g]),
					.ovf_reg(ovf[g])
				);
				assign cnt8[g] = 8'h00;
			end else begin : g_narrow
				assign tick[g] = tick_sel(ctrl_reg[g][`TEC_PSC_HI:`TEC_PSC_LO], psc_reg);
				tec_unit #(.WIDTH(8)) u_unit (
					.pclk(pclk),
					.presetn(presetn),
					.mode(ctrl_reg[g][`TEC_MODE_HI:`TEC_MODE_LO]),
					.run(ctrl_reg[g][`TEC_RUN_BIT]),
					.edge_sel(ctrl_reg[g][`TEC_EDGE_BIT]),
					.int_tick(tick[g]),
					.pin(ext_event_pin[g]),
					.load(load[g]),
					.load_data(pwdata[7:0]),
					.count_reg(cnt8[g]),
					.run_clear(run_clear[g]),
					.ovf_reg(ovf[g])
				);
			end
		end
	endgenerate

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < 4; i = i + 1)
				ctrl_reg[i] <= `TEC_CTRL_RST;
			irq_stat_reg <= 4'h0;
			irq_en_reg <= 4'h0;
		end else begin
			for (i = 0; i < 4; i = i + 1) begin
				if (wr && paddr == (`TEC_OFF_CTRL0 + 4 * i))
					ctrl_reg[i] <= pwdata[7:0] & ctrl_mask(i[1:0]);
				else if (run_clear[i])
					ctrl_reg[i][`TEC_RUN_BIT] <= 1'b0;
			end
			if (wr && paddr == `TEC_OFF_IRQ_EN)
				irq_en_reg <= pwdata[3:0];
			// Set wins over clear
			irq_stat_reg <= (irq_stat_reg & ~((wr && paddr == `TEC_OFF_IRQ_CLR) ?
				pwdata[3:0] : 4'h0)) | ovf;
		end
	end

	assign irq = |(irq_stat_reg & irq_en_reg);

	// Both bytes of the wide count come from the same register read
	always @* begin
		prdata = 32'h00000000;
		if (rd) begin
			case (paddr)
				`TEC_OFF_CTRL0: prdata = {24'h000000, ctrl_reg[0]};
				`TEC_OFF_CTRL1: prdata = {24'h000000, ctrl_reg[1]};
				`TEC_OFF_CTRL2: prdata = {24'h000000, ctrl_reg[2]};
				`TEC_OFF_CTRL3: prdata = {24'h000000, ctrl_reg[3]};
				`TEC_OFF_CNT0: prdata = {24'h000000, cnt8[0]};
				`TEC_OFF_CNT1: prdata = {16'h0000, cnt16};
				`TEC_OFF_CNT2: prdata = {24'h000000, cnt8[2]};
				`TEC_OFF_CNT3: prdata = {24'h000000, cnt8[3]};
				`TEC_OFF_IRQ_STAT: prdata = {28'h0000000, irq_stat_reg};
				`TEC_OFF_IRQ_EN: prdata = {28'h0000000, irq_en_reg};
				default: prdata = 32'h00000000;
			endcase
		end
	end
endmodule // tec_top

// File: tec_assertions.sv
// Purpose: Port checks on tec_top
// Assumes: Zero wait APB slave
// Notes: Bound to tec_top below
`timescale 1ns/1ps
`include "tec_map.vh"
module tec_chk (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd = psel && penable && !pwrite;
	wire wr = psel && penable && pwrite;
	property p_rdy; psel |-> pready && !pslverr; endproperty
	a_rdy: assert property (p_rdy) else $error("ready or error wrong");
	property p_idle; !rd |-> prdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data outside read");
	property p_unm; rd && paddr == 12'h100 |-> prdata == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_c8; rd && paddr == `TEC_OFF_CTRL0 |-> prdata[5] == 1'b0 && prdata[31:8] == 24'h0; endproperty
	a_c8: assert property (p_c8) else $error("ctrl0 reserved bits");
	property p_c16; rd && paddr == `TEC_OFF_CTRL1 |-> prdata[2:0] == 3'h0; endproperty
	a_c16: assert property (p_c16) else $error("ctrl1 reserved bits");
	property p_n8; rd && paddr == `TEC_OFF_CNT2 |-> prdata[31:8] == 24'h0; endproperty
	a_n8: assert property (p_n8) else $error("count2 too wide");
	property p_n16; rd && paddr == `TEC_OFF_CNT1 |-> prdata[31:16] == 16'h0; endproperty
	a_n16: assert property (p_n16) else $error("count1 too wide");
	property p_irq; wr && paddr == `TEC_OFF_IRQ_EN && pwdata[3:0] == 4'h0 |=> !irq; endproperty
	a_irq: assert property (p_irq) else $error("irq while disabled");
	c_rd: cover property (rd && irq);
	c_w16: cover property (wr && paddr == `TEC_OFF_CNT1);
	c_irq: cover property ($rose(irq));
endmodule // tec_chk
bind tec_top tec_chk tec_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .irq);

// File: tec_pin_model.sv
// Purpose: Timer input pins and sub clock tick
// Assumes: Pins idle low
// Notes: Tick every 8 cycles
`timescale 1ns/1ps
module tec_pin_model (
	input wire pclk,
	output reg [3:0] pin,
	output reg tick
);
	reg [2:0] div = 3'h0;
	initial pin = 4'h0;
	initial tick = 1'b0;
	always @(posedge pclk) begin
		div <= div + 3'h1;
		tick <= (div == 3'h7);
	end
	task tog(input integer u, input integer n);
		repeat (n) begin
			@(posedge pclk) pin[u] <= ~pin[u];
			repeat (3) @(posedge pclk);
		end
	endtask
endmodule // tec_pin_model

// File: tec_tb.sv
// Purpose: Self-checking bench for tec_top
// Assumes: Zero wait APB
// Notes: Pins from tec_pin_model
`timescale 1ns/1ps
`include "tec_map.vh"
module testbench;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [11:0] paddr = 12'h0;
	reg [31:0] pwdata = 32'h0;
	reg [31:0] d, a;
	wire [31:0] prdata;
	wire pready, pslverr, irq, tick;
	wire [3:0] pin;
	integer errors = 0;
	integer comparisons = 0;
	integer cyc = 0;
	integer c;
	initial forever #5 pclk = ~pclk;
	tec_pin_model tec_pin_model_i (.pclk(pclk), .pin(pin), .tick(tick));
	tec_top tec_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_event_pin(pin), .sub_clk_tick(tick), .irq(irq));
	task close_out;
		begin
			$display("comparisons %0d errors %0d", comparisons, errors);
			if (errors == 0 && comparisons > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			close_out;
		end
	end
	task chk(input [63:0] n, input [31:0] s, input [31:0] x);
		begin
			comparisons = comparisons + 1;
			if (s !== x) begin
				errors = errors + 1;
				$display("[ERR] %0s exp %h got %h", n, x, s);
			end
		end
	endtask
	task xf(input w, input [11:0] ad, input [31:0] wd, output [31:0] r);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= ad;
			pwdata <= wd;
			@(posedge pclk) penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) @(posedge pclk);
			r = prdata;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task t_rst;
		begin
			xf(0, `TEC_OFF_CTRL1, 0, d);
			chk("ctrl1", d, 32'h08);
			xf(0, `TEC_OFF_CNT1, 0, d);
			chk("cnt1", d, 0);
			xf(0, 12'h100, 0, d);
			chk("unmap", d, 0);
			xf(1, `TEC_OFF_CTRL0, 32'hff, d);
			xf(1, `TEC_OFF_CTRL1, 32'hff, d);
			xf(0, `TEC_OFF_CTRL0, 0, d);
			chk("ctrl0", d, 32'hdf);
			xf(0, `TEC_OFF_CTRL1, 0, d);
			chk("ctrl1", d, 32'hf8);
			xf(1, `TEC_OFF_CTRL0, 32'h08, d);
			xf(1, `TEC_OFF_CTRL1, 32'h08, d);
			$display("t_rst done");
		end
	endtask
	task t_evt;
		begin
			xf(1, `TEC_OFF_CNT0, 32'hfe, d);
			xf(1, `TEC_OFF_CTRL0, 32'h57, d);
			xf(1, `TEC_OFF_IRQ_EN, 32'h1, d);
			tec_pin_model_i.tog(0, 6);
			xf(0, `TEC_OFF_CNT0, 0, d);
			chk("cnt0", d, 32'hff);
			xf(0, `TEC_OFF_IRQ_STAT, 0, d);
			chk("stat", d, 32'h1);
			chk("irq", irq, 1);
			xf(1, `TEC_OFF_IRQ_CLR, 32'h1, d);
			chk("irq", irq, 0);
			xf(1, `TEC_OFF_CTRL0, 32'h5f, d);
			tec_pin_model_i.tog(0, 2);
			xf(0, `TEC_OFF_CNT0, 0, d);
			chk("cnt0", d, 32'hfe);
			xf(1, `TEC_OFF_CTRL0, 32'h18, d);
			tec_pin_model_i.tog(0, 2);
			xf(0, `TEC_OFF_CNT0, 0, d);
			chk("cnt0", d, 32'hfe);
			$display("t_evt done");
		end
	endtask
	task t_tmr(input w, input [11:0] ca, input [11:0] na, input [31:0] m);
		for (c = 0; c < 10; c = c + 1) begin
			xf(1, ca, (c < 8) ? 32'h90 | c : (c == 8 ? 32'h90 : 32'hb0), d);
			xf(0, na, 0, a);
			// Samples 256 edges apart
			repeat (253) @(posedge pclk);
			xf(0, na, 0, d);
			chk("delta", (d - a) & m, (w ? (c == 9 ? 32 : 64) : (c < 8 ? 256 >> c : 256)) & m);
		end
	endtask
	task t_pw;
		begin
			xf(1, `TEC_OFF_CNT3, 0, d);
			xf(1, `TEC_OFF_CTRL3, 32'hd8, d);
			repeat (10) @(posedge pclk);
			xf(0, `TEC_OFF_CNT3, 0, d);
			chk("cnt3", d, 0);
			tec_pin_model_i.tog(3, 1);
			repeat (20) @(posedge pclk);
			tec_pin_model_i.tog(3, 1);
			xf(0, `TEC_OFF_CTRL3, 0, d);
			chk("ctrl3", d, 32'hc8);
			xf(0, `TEC_OFF_CNT3, 0, a);
			chk("width", a, 32'd23);
			tec_pin_model_i.tog(3, 2);
			xf(0, `TEC_OFF_CNT3, 0, d);
			chk("cnt3", d, a);
			$display("t_pw done");
		end
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_rst;
		t_evt;
		xf(1, `TEC_OFF_CNT2, 0, d);
		t_tmr(0, `TEC_OFF_CTRL2, `TEC_OFF_CNT2, 32'hff);
		xf(1, `TEC_OFF_CNT1, 32'h1200, d);
		c = 0;
		t_tmr(1, `TEC_OFF_CTRL1, `TEC_OFF_CNT1, 32'hffff);
		$display("t_tmr done");
		t_pw;
		close_out;
	end
endmodule // testbench
